// ==== mos_proc_end.sv ====
// processor end: ordering model field and transaction issue ordering
`timescale 1ns/1ps
`include "mos_map.svh"
module mos_proc_end
#(
   parameter bit SUPPORT_RELAXED = 1'b1
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // link
   mos_link_if.proc link,
   // ordering model field
   input wire logic field_wr,
   input wire logic [`MOS_FIELD_W-1:0] field_wdata,
   output logic [`MOS_FIELD_W-1:0] ordering_model_field,
   // instruction fetch
   input wire logic fetch_valid,
   input wire logic [`MOS_ADDR_W-1:0] fetch_addr,
   output logic fetch_ready,
   output logic fetch_done,
   output logic [`MOS_DATA_W-1:0] fetch_data,
   // data access
   input wire logic op_valid,
   input wire mos_pkg::mos_kind_type op_kind,
   input wire logic [`MOS_ADDR_W-1:0] op_addr,
   input wire logic [`MOS_DATA_W-1:0] op_wdata,
   output logic op_ready,
   output logic [`MOS_TAG_W-1:0] op_tag,
   output logic op_done,
   output logic [`MOS_TAG_W-1:0] op_done_tag,
   output logic [`MOS_DATA_W-1:0] op_done_rdata,
   // status
   output logic [`MOS_COUNT_W-1:0] outstanding
);
   // ==========================================
   // ordering model field
   mos_pkg::mos_field_type field;
   mos_pkg::mos_field_type next_field;
   logic write_ok;
   assign write_ok = (field_wdata == `MOS_FIELD_TOTAL) || (field_wdata == `MOS_FIELD_RELAXED);
   // unsupported encodings fall back to zero, never above the value written
   assign next_field = write_ok ? field_wdata : `MOS_FIELD_TOTAL;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         field <= `MOS_FIELD_RESET;
      end
      else if (field_wr && SUPPORT_RELAXED)
      begin
         field <= next_field;
      end
   end
   assign ordering_model_field = SUPPORT_RELAXED ? field : `MOS_FIELD_TOTAL;
   // ==========================================
   // model decode
   logic model_total;
   logic model_relaxed;
   assign model_total = (ordering_model_field == `MOS_FIELD_TOTAL);
   assign model_relaxed = (ordering_model_field == `MOS_FIELD_RELAXED);
   // ==========================================
   // outstanding data transactions
   logic [`MOS_SLOTS-1:0] ent_valid;
   mos_pkg::mos_kind_type ent_kind [`MOS_SLOTS];
   mos_pkg::mos_addr_type ent_addr [`MOS_SLOTS];
   logic [`MOS_SLOTS-1:0] same_addr;
   logic [`MOS_SLOTS-1:0] has_load;
   logic [`MOS_SLOTS-1:0] set_ent;
   logic [`MOS_SLOTS-1:0] clr_ent;
   logic [`MOS_SLOTS-1:0] cnt_bits;
   genvar gi;
   generate
      for (gi = 0; gi < `MOS_SLOTS; gi++)
      begin : g_ent
         assign same_addr[gi] = ent_valid[gi] && (ent_addr[gi] == op_addr);
         assign has_load[gi] = ent_valid[gi] && (ent_kind[gi] != mos_pkg::mos_store);
         assign set_ent[gi] = link.d_req_valid && link.d_req_ready && (op_tag == gi);
         assign clr_ent[gi] = link.d_ack_valid && (link.d_ack_tag == gi);
         assign cnt_bits[gi] = ent_valid[gi];
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               ent_valid[gi] <= 1'b0;
               ent_kind[gi] <= mos_pkg::mos_load;
               ent_addr[gi] <= '0;
            end
            else if (set_ent[gi])
            begin
               ent_valid[gi] <= 1'b1;
               ent_kind[gi] <= op_kind;
               ent_addr[gi] <= op_addr;
            end
            else if (clr_ent[gi])
            begin
               ent_valid[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   // ==========================================
   // free entry search
   logic free_found;
   always_comb
   begin
      free_found = 1'b0;
      op_tag = '0;
      for (int k = 0; k < `MOS_SLOTS; k++)
      begin
         if (!free_found && !ent_valid[k])
         begin
            free_found = 1'b1;
            op_tag = k[`MOS_TAG_W-1:0];
         end
      end
   end
   always_comb
   begin
      outstanding = '0;
      for (int k = 0; k < `MOS_SLOTS; k++)
      begin
         outstanding = outstanding + `MOS_COUNT_W'(cnt_bits[k]);
      end
   end
   // ==========================================
   // issue ordering
   logic any_out;
   logic any_load;
   logic any_same;
   logic block_total;
   logic block_weak;
   logic blocked;
   logic can_issue;
   assign any_out = (ent_valid != '0);
   assign any_load = (has_load != '0);
   assign any_same = (same_addr != '0);
   // loads wait on loads, atomics and same-address stores only
   assign block_total = (op_kind == mos_pkg::mos_load) ? (any_load || any_same) : any_out;
   // a store or atomic waits for every earlier access to complete
   // weaker model keeps only same-location order
   assign block_weak = any_same;
   assign blocked = model_total ? block_total : (model_relaxed ? block_weak : block_total);
   assign can_issue = op_valid && free_found && !blocked;
   // ==========================================
   // data path drive
   assign link.d_req_valid = can_issue;
   assign link.d_req_kind = op_kind;
   assign link.d_req_addr = op_addr;
   assign link.d_req_wdata = op_wdata;
   assign link.d_req_tag = op_tag;
   assign op_ready = can_issue && link.d_req_ready;
   // no local data cache: every data access goes to the shared memory
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         op_done <= 1'b0;
         op_done_tag <= '0;
         op_done_rdata <= '0;
      end
      else
      begin
         op_done <= link.d_ack_valid;
         op_done_tag <= link.d_ack_tag;
         op_done_rdata <= link.d_ack_rdata;
      end
   end
   // ==========================================
   // instruction path, no snooping of stores
   logic fetch_busy;
   logic fetch_go;
   assign fetch_go = fetch_valid && !fetch_busy && link.i_req_ready;
   assign link.i_req_valid = fetch_valid && !fetch_busy;
   assign link.i_req_addr = fetch_addr;
   assign fetch_ready = fetch_go;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fetch_busy <= 1'b0;
         fetch_done <= 1'b0;
         fetch_data <= '0;
      end
      else
      begin
         if (fetch_go)
         begin
            fetch_busy <= 1'b1;
         end
         else if (link.i_ack_valid)
         begin
            fetch_busy <= 1'b0;
         end
         fetch_done <= link.i_ack_valid;
         fetch_data <= link.i_ack_data;
      end
   end
endmodule

// ==== mos_map.svh ====
// constants of the memory ordering select block
`ifndef MOS_MAP_SVH
`define MOS_MAP_SVH
`define MOS_ADDR_W 4
`define MOS_DATA_W 32
`define MOS_MEM_DEPTH 16
`define MOS_SLOTS 4
`define MOS_TAG_W 2
`define MOS_COUNT_W 3
`define MOS_FIELD_W 2
`define MOS_FIELD_TOTAL 2'h0
`define MOS_FIELD_PARTIAL 2'h1
`define MOS_FIELD_RELAXED 2'h2
`define MOS_FIELD_IMPL 2'h3
`define MOS_FIELD_RESET 2'h0
`define MOS_LFSR_RESET 4'h9
`endif

// ==== mos_pkg.sv ====
// types of the memory ordering select block
`include "mos_map.svh"
package mos_pkg;
   typedef logic [`MOS_ADDR_W-1:0] mos_addr_type;
   typedef logic [`MOS_DATA_W-1:0] mos_data_type;
   typedef logic [`MOS_TAG_W-1:0] mos_tag_type;
   typedef logic [`MOS_FIELD_W-1:0] mos_field_type;
   typedef enum logic [1:0] {mos_load, mos_store, mos_atomic} mos_kind_type;
endpackage

// ==== mos_link_if.sv ====
// link between processor end and shared memory end
`timescale 1ns/1ps
`include "mos_map.svh"
interface mos_link_if;
   // instruction path
   logic i_req_valid;
   logic i_req_ready;
   mos_pkg::mos_addr_type i_req_addr;
   logic i_ack_valid;
   mos_pkg::mos_data_type i_ack_data;
   // data path
   logic d_req_valid;
   logic d_req_ready;
   mos_pkg::mos_kind_type d_req_kind;
   mos_pkg::mos_addr_type d_req_addr;
   mos_pkg::mos_data_type d_req_wdata;
   mos_pkg::mos_tag_type d_req_tag;
   logic d_ack_valid;
   mos_pkg::mos_tag_type d_ack_tag;
   mos_pkg::mos_data_type d_ack_rdata;
   modport proc
   (
      output i_req_valid, i_req_addr, d_req_valid, d_req_kind, d_req_addr,
      output d_req_wdata, d_req_tag,
      input i_req_ready, i_ack_valid, i_ack_data, d_req_ready, d_ack_valid,
      input d_ack_tag, d_ack_rdata
   );
   modport mem
   (
      input i_req_valid, i_req_addr, d_req_valid, d_req_kind, d_req_addr,
      input d_req_wdata, d_req_tag,
      output i_req_ready, i_ack_valid, i_ack_data, d_req_ready, d_ack_valid,
      output d_ack_tag, d_ack_rdata
   );
endinterface

// ==== mos_memory_end.sv ====
// shared memory end: accepts, performs and acknowledges transactions
`timescale 1ns/1ps
`include "mos_map.svh"
module mos_memory_end
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // link
   mos_link_if.mem link,
   // user side
   input wire logic hold,
   output logic [`MOS_COUNT_W-1:0] pending
);
   // ==========================================
   // storage and pending queue
   mos_pkg::mos_data_type mem [`MOS_MEM_DEPTH];
   mos_pkg::mos_kind_type q_kind [`MOS_SLOTS];
   mos_pkg::mos_addr_type q_addr [`MOS_SLOTS];
   mos_pkg::mos_data_type q_wdata [`MOS_SLOTS];
   mos_pkg::mos_tag_type q_tag [`MOS_SLOTS];
   mos_pkg::mos_kind_type next_kind [`MOS_SLOTS];
   mos_pkg::mos_addr_type next_addr [`MOS_SLOTS];
   mos_pkg::mos_data_type next_wdata [`MOS_SLOTS];
   mos_pkg::mos_tag_type next_tag [`MOS_SLOTS];
   logic [`MOS_COUNT_W-1:0] count;
   logic [3:0] lfsr;
   logic [`MOS_SLOTS-1:0] eligible;
   logic [`MOS_TAG_W-1:0] pick;
   logic found;
   logic done;
   logic accept;
   logic [`MOS_COUNT_W-1:0] count_after;
   mos_pkg::mos_addr_type done_addr;
   mos_pkg::mos_kind_type done_kind;
   // ==========================================
   // selection of the slot to perform
   genvar gi;
   generate
      for (gi = 0; gi < `MOS_SLOTS; gi++)
      begin : g_elig
         logic [`MOS_SLOTS-1:0] older_same;
         for (genvar gj = 0; gj < `MOS_SLOTS; gj++)
         begin : g_old
            assign older_same[gj] = (gj < gi) && (q_addr[gj] == q_addr[gi]);
         end
         assign eligible[gi] = (gi < count) && (older_same == '0);
      end
   endgenerate
   always_comb
   begin
      logic [`MOS_TAG_W-1:0] idx;
      idx = '0;
      found = 1'b0;
      pick = '0;
      for (int k = 0; k < `MOS_SLOTS; k++)
      begin
         idx = lfsr[`MOS_TAG_W-1:0] + k[`MOS_TAG_W-1:0];
         if (!found && eligible[idx])
         begin
            found = 1'b1;
            pick = idx;
         end
      end
   end
   assign done = found && !hold;
   assign done_addr = q_addr[pick];
   assign done_kind = q_kind[pick];
   assign accept = link.d_req_valid && link.d_req_ready;
   assign link.d_req_ready = (count < `MOS_COUNT_W'(`MOS_SLOTS)) && !hold;
   assign link.i_req_ready = 1'b1;
   assign count_after = count - `MOS_COUNT_W'(done);
   assign pending = count;
   // ==========================================
   // queue compaction and append
   generate
      for (gi = 0; gi < `MOS_SLOTS; gi++)
      begin : g_next
         logic shift;
         logic load_new;
         mos_pkg::mos_kind_type up_kind;
         mos_pkg::mos_addr_type up_addr;
         mos_pkg::mos_data_type up_wdata;
         mos_pkg::mos_tag_type up_tag;
         // top slot takes an empty entry when the queue moves down
         if (gi == `MOS_SLOTS-1)
         begin : g_top
            assign up_kind = mos_pkg::mos_load;
            assign up_addr = '0;
            assign up_wdata = '0;
            assign up_tag = '0;
         end
         else
         begin : g_mid
            assign up_kind = q_kind[gi+1];
            assign up_addr = q_addr[gi+1];
            assign up_wdata = q_wdata[gi+1];
            assign up_tag = q_tag[gi+1];
         end
         assign shift = done && (gi >= pick);
         assign load_new = accept && (count_after == `MOS_COUNT_W'(gi));
         assign next_kind[gi] = load_new ? link.d_req_kind : (shift ? up_kind : q_kind[gi]);
         assign next_addr[gi] = load_new ? link.d_req_addr : (shift ? up_addr : q_addr[gi]);
         assign next_wdata[gi] = load_new ? link.d_req_wdata : (shift ? up_wdata : q_wdata[gi]);
         assign next_tag[gi] = load_new ? link.d_req_tag : (shift ? up_tag : q_tag[gi]);
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               q_kind[gi] <= mos_pkg::mos_load;
               q_addr[gi] <= '0;
               q_wdata[gi] <= '0;
               q_tag[gi] <= '0;
            end
            else
            begin
               q_kind[gi] <= next_kind[gi];
               q_addr[gi] <= next_addr[gi];
               q_wdata[gi] <= next_wdata[gi];
               q_tag[gi] <= next_tag[gi];
            end
         end
      end
   endgenerate
   // ==========================================
   // perform and acknowledge
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= '0;
         lfsr <= `MOS_LFSR_RESET;
         link.d_ack_valid <= 1'b0;
         link.d_ack_tag <= '0;
         link.d_ack_rdata <= '0;
         link.i_ack_valid <= 1'b0;
         link.i_ack_data <= '0;
      end
      else
      begin
         count <= count_after + `MOS_COUNT_W'(accept);
         lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
         link.d_ack_valid <= done;
         link.d_ack_tag <= q_tag[pick];
         link.d_ack_rdata <= mem[done_addr];
         link.i_ack_valid <= link.i_req_valid;
         link.i_ack_data <= mem[link.i_req_addr];
      end
   end
   // single array, one write a cycle: one visible order per location
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int m = 0; m < `MOS_MEM_DEPTH; m++)
         begin
            mem[m] <= '0;
         end
      end
      else if (done && (done_kind != mos_pkg::mos_load))
      begin
         mem[done_addr] <= q_wdata[pick];
      end
   end
endmodule

// ==== mos_asserts.sv ====
// link checker of the memory ordering select block
`timescale 1ns/1ps
`include "mos_map.svh"
module mos_asserts
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // field and link
   input wire logic [`MOS_FIELD_W-1:0] ordering_model_field,
   input wire logic i_req_valid,
   input wire logic i_req_ready,
   input wire logic i_ack_valid,
   input wire logic d_req_valid,
   input wire logic d_req_ready,
   input wire mos_pkg::mos_kind_type d_req_kind,
   input wire mos_pkg::mos_addr_type d_req_addr,
   input wire mos_pkg::mos_data_type d_req_wdata,
   input wire mos_pkg::mos_tag_type d_req_tag,
   input wire logic d_ack_valid,
   input wire mos_pkg::mos_tag_type d_ack_tag,
   input wire mos_pkg::mos_data_type d_ack_rdata
);
   // ==========
   // outstanding entries and memory shadow
   logic [3:0] out_v;
   logic [3:0] hit;
   logic [3:0] rd;
   mos_pkg::mos_addr_type out_a [4];
   mos_pkg::mos_kind_type out_k [4];
   mos_pkg::mos_data_type out_w [4];
   mos_pkg::mos_data_type shadow [16];
   wire d_acc = d_req_valid && d_req_ready;
   wire i_acc = i_req_valid && i_req_ready;
   wire total = ordering_model_field == `MOS_FIELD_TOTAL;
   wire [3:0] clr = d_ack_valid ? 4'h1 << d_ack_tag : 4'h0;
   wire [3:0] next_out_v = (out_v & ~clr) | (d_acc ? 4'h1 << d_req_tag : 4'h0);
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         hit[i] = out_v[i] && out_a[i] == d_req_addr;
         rd[i] = out_v[i] && out_k[i] != mos_pkg::mos_store;
      end
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         out_v <= 4'h0;
      else
         out_v <= next_out_v;
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         shadow <= '{default: 32'h0};
      else if (d_ack_valid && out_k[d_ack_tag] != mos_pkg::mos_load)
         shadow[out_a[d_ack_tag]] <= out_w[d_ack_tag];
   end
   always_ff @(posedge mclk)
   begin
      if (d_acc)
      begin
         out_a[d_req_tag] <= d_req_addr;
         out_k[d_req_tag] <= d_req_kind;
         out_w[d_req_tag] <= d_req_wdata;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence s_ack_pulse;
      i_ack_valid ##1 !i_ack_valid;
   endsequence
   sequence s_fetch_busy;
      !i_acc;
   endsequence
   property p_fetch_ack;
      i_acc |=> s_ack_pulse;
   endproperty
   a_fetch_ack: assert property (p_fetch_ack)
      else $error("fetch answer missing");
   property p_fetch_one;
      i_acc |=> s_fetch_busy;
   endproperty
   a_fetch_one: assert property (p_fetch_one)
      else $error("second fetch while busy");
   property p_fetch_take;
      i_req_ready;
   endproperty
   a_fetch_take: assert property (p_fetch_take)
      else $error("fetch refused");
   property p_tag_free;
      d_acc |-> !out_v[d_req_tag];
   endproperty
   a_tag_free: assert property (p_tag_free)
      else $error("tag reused while busy");
   property p_ack_owned;
      d_ack_valid |-> out_v[d_ack_tag];
   endproperty
   a_ack_owned: assert property (p_ack_owned)
      else $error("ack without request");
   property p_same_loc;
      d_acc |-> hit == 4'h0;
   endproperty
   a_same_loc: assert property (p_same_loc)
      else $error("two requests to one location");
   property p_ack_data;
      d_ack_valid |-> d_ack_rdata == shadow[out_a[d_ack_tag]];
   endproperty
   a_ack_data: assert property (p_ack_data)
      else $error("wrong old value");
   property p_total_store;
      d_acc && total && d_req_kind != mos_pkg::mos_load |-> out_v == 4'h0;
   endproperty
   a_total_store: assert property (p_total_store)
      else $error("store passed earlier access");
   property p_total_load;
      d_acc && total && d_req_kind == mos_pkg::mos_load |-> rd == 4'h0;
   endproperty
   a_total_load: assert property (p_total_load)
      else $error("load passed earlier load");
   property p_field_legal;
      ordering_model_field != `MOS_FIELD_PARTIAL && ordering_model_field != `MOS_FIELD_IMPL;
   endproperty
   a_field_legal: assert property (p_field_legal)
      else $error("unsupported model held");
endmodule

// ==== memory_ordering_model_select_tb.sv ====
// testbench of the memory ordering select block
`timescale 1ns/1ps
`include "mos_map.svh"
module memory_ordering_model_select_tb;
   // ==========
   // signals
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hold = 1'b0;
   logic field_wr = 1'b0;
   logic [1:0] field_wdata = 2'h0;
   logic fetch_valid = 1'b0;
   logic [3:0] fetch_addr = 4'h0;
   logic op_valid = 1'b0;
   mos_pkg::mos_kind_type op_kind = mos_pkg::mos_load;
   logic [3:0] op_addr = 4'h0;
   logic [31:0] op_wdata = 32'h0;
   logic [1:0] field;
   logic [1:0] field_total;
   logic fetch_ready;
   logic fetch_done;
   logic [31:0] fetch_data;
   logic [31:0] fdat;
   logic op_ready;
   logic [1:0] op_tag;
   logic op_done;
   logic [1:0] op_done_tag;
   logic [31:0] op_done_rdata;
   logic [2:0] outstanding;
   logic [2:0] pending;
   logic dn [4];
   logic [31:0] dd [4];
   int n_fetch = 0;
   int n_mismatch = 0;
   int checks = 0;
   always #50 mclk = ~mclk;
   always @(posedge mclk)
   begin
      if (op_done === 1'b1)
      begin
         dn[op_done_tag] <= 1'b1;
         dd[op_done_tag] <= op_done_rdata;
      end
      if (fetch_done === 1'b1)
      begin
         n_fetch <= n_fetch + 1;
         fdat <= fetch_data;
      end
   end
   // ==========
   // the two ends and the checker
   mos_link_if link_i ();
   mos_proc_end mos_proc_end_i (.mclk(mclk), .rst_b(rst_b), .link(link_i),
      .field_wr(field_wr), .field_wdata(field_wdata), .ordering_model_field(field),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
      .fetch_done(fetch_done), .fetch_data(fetch_data), .op_valid(op_valid),
      .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata), .op_ready(op_ready),
      .op_tag(op_tag), .op_done(op_done), .op_done_tag(op_done_tag),
      .op_done_rdata(op_done_rdata), .outstanding(outstanding));
   mos_memory_end mos_memory_end_i (.mclk(mclk), .rst_b(rst_b), .link(link_i),
      .hold(hold), .pending(pending));
   // store-order-only build, field path only
   mos_link_if link_total_i ();
   assign link_total_i.i_req_ready = 1'b0;
   assign link_total_i.i_ack_valid = 1'b0;
   assign link_total_i.i_ack_data = '0;
   assign link_total_i.d_req_ready = 1'b0;
   assign link_total_i.d_ack_valid = 1'b0;
   assign link_total_i.d_ack_tag = '0;
   assign link_total_i.d_ack_rdata = '0;
   mos_proc_end #(.SUPPORT_RELAXED(1'b0)) mos_proc_end_total_i (.mclk(mclk), .rst_b(rst_b),
      .link(link_total_i), .field_wr(field_wr), .field_wdata(field_wdata),
      .ordering_model_field(field_total), .fetch_valid(1'b0), .fetch_addr(4'h0),
      .fetch_ready(), .fetch_done(), .fetch_data(), .op_valid(1'b0),
      .op_kind(mos_pkg::mos_load), .op_addr(4'h0), .op_wdata(32'h0), .op_ready(),
      .op_tag(), .op_done(), .op_done_tag(), .op_done_rdata(), .outstanding());
   mos_asserts mos_asserts_i (.mclk(mclk), .rst_b(rst_b), .ordering_model_field(field),
      .i_req_valid(link_i.i_req_valid), .i_req_ready(link_i.i_req_ready),
      .i_ack_valid(link_i.i_ack_valid), .d_req_valid(link_i.d_req_valid),
      .d_req_ready(link_i.d_req_ready), .d_req_kind(link_i.d_req_kind),
      .d_req_addr(link_i.d_req_addr), .d_req_wdata(link_i.d_req_wdata),
      .d_req_tag(link_i.d_req_tag), .d_ack_valid(link_i.d_ack_valid),
      .d_ack_tag(link_i.d_ack_tag), .d_ack_rdata(link_i.d_ack_rdata));
   // ==========
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wfld(input logic [1:0] v);
      field_wr = 1'b1;
      field_wdata = v;
      @(negedge mclk);
      field_wr = 1'b0;
      @(negedge mclk);
   endtask
   // holds the request until taken, returns wait cycles
   task automatic iss(input mos_pkg::mos_kind_type k, input logic [3:0] a,
      input logic [31:0] d, output logic [1:0] t, output int w);
      op_valid = 1'b1;
      op_kind = k;
      op_addr = a;
      op_wdata = d;
      w = 0;
      #1;
      while (op_ready !== 1'b1 && w < 100)
      begin
         @(negedge mclk);
         w++;
      end
      if (w >= 100)
      begin
         n_mismatch++;
         finish_test();
      end
      t = op_tag;
      @(negedge mclk);
      dn[t] = 1'b0;
   endtask
   task automatic wdone(input logic [1:0] t, input logic [31:0] exp);
      int n;
      n = 0;
      while (dn[t] !== 1'b1 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= 100)
      begin
         n_mismatch++;
         finish_test();
      end
      chk(dd[t], exp);
   endtask
   // ==========
   // scenarios
   task automatic t_reset;
      chk(field, 32'h0);
      chk(outstanding, 32'h0);
      chk(pending, 32'h0);
   endtask
   task automatic t_field;
      for (int v = 0; v < 4; v++)
      begin
         wfld(v[1:0]);
         chk(field, v == 2 ? v : 0);
         chk(field_total, 32'h0);
      end
   endtask
   task automatic t_total;
      logic [1:0] t;
      int w;
      iss(mos_pkg::mos_load, 4'h1, 32'h0, t, w);
      chk(outstanding, 32'h1);
      chk(pending, 32'h1);
      iss(mos_pkg::mos_store, 4'h2, 32'h5, t, w);
      chk(w > 0, 1'b1);
      iss(mos_pkg::mos_load, 4'h4, 32'h0, t, w);
      chk(w == 0, 1'b1);
      iss(mos_pkg::mos_store, 4'h6, 32'h6, t, w);
      chk(w > 0, 1'b1);
      iss(mos_pkg::mos_load, 4'h2, 32'h0, t, w);
      op_valid = 1'b0;
      wdone(t, 32'h5);
   endtask
   task automatic t_relaxed;
      logic [1:0] t;
      int w;
      wfld(2'h2);
      for (int i = 8; i < 11; i++)
      begin
         iss(mos_pkg::mos_store, i[3:0], i, t, w);
         chk(w == 0, 1'b1);
      end
      iss(mos_pkg::mos_load, 4'ha, 32'h0, t, w);
      chk(w > 0, 1'b1);
      op_valid = 1'b0;
      wdone(t, 32'ha);
      wfld(2'h0);
      iss(mos_pkg::mos_store, 4'hb, 32'hb, t, w);
      iss(mos_pkg::mos_store, 4'hc, 32'hc, t, w);
      chk(w > 0, 1'b1);
      op_valid = 1'b0;
      wdone(t, 32'h0);
   endtask
   task automatic t_hold;
      logic [1:0] t;
      int w;
      hold = 1'b1;
      op_valid = 1'b1;
      op_kind = mos_pkg::mos_atomic;
      op_addr = 4'h2;
      repeat (3) @(negedge mclk);
      chk(op_ready, 1'b0);
      hold = 1'b0;
      iss(mos_pkg::mos_atomic, 4'h2, 32'h7, t, w);
      op_valid = 1'b0;
      wdone(t, 32'h5);
      iss(mos_pkg::mos_load, 4'h2, 32'h0, t, w);
      op_valid = 1'b0;
      wdone(t, 32'h7);
   endtask
   task automatic t_fetch;
      int n;
      n = n_fetch;
      fetch_valid = 1'b1;
      fetch_addr = 4'h2;
      #1;
      chk(fetch_ready, 1'b1);
      @(negedge mclk);
      chk(fetch_ready, 1'b0);
      repeat (5) @(negedge mclk);
      fetch_valid = 1'b0;
      repeat (4) @(negedge mclk);
      chk(n_fetch - n, 32'h3);
      chk(fdat, 32'h7);
   endtask
   // ==========
   // main sequence and watchdog
   initial
   begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      t_reset();
      t_field();
      t_total();
      t_relaxed();
      t_hold();
      t_fetch();
      finish_test();
   end
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      finish_test();
   end
endmodule
